/* src/irq_src_pkg.sv */
// Constants shared by the vectored interrupt source controller
package irq_src_pkg;
    localparam int unsigned NUM_SRC      = 29;
    localparam int unsigned NUM_PINS     = 8;
    localparam int unsigned NUM_KEYS     = 8;
    localparam int unsigned FLAG_W       = 32;
    localparam logic [31:0] REQ_RESET    = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET   = 32'hffff_ffff;
    localparam logic [31:0] PRIO_RESET   = 32'hffff_ffff;
    localparam logic [7:0]  EDGE_RESET   = 8'h00;
    localparam logic [7:0]  KEY_RESET    = 8'h00;
    localparam logic [15:0] VEC_BASE     = 16'h0004;
    localparam logic [15:0] VEC_BREAK    = 16'h003e;
    localparam logic [15:0] VEC_RESET    = 16'h0000;
    localparam logic [4:0]  SRC_LOWVOLT  = 5'h00;
    localparam logic [4:0]  SRC_PIN0     = 5'h01;
    localparam logic [4:0]  SRC_PIN6     = 5'h16;
    localparam logic [4:0]  SRC_DUAL0    = 5'h0a;
    localparam logic [4:0]  SRC_TIMER51  = 5'h13;
    localparam logic [4:0]  SRC_KEY      = 5'h14;
    localparam logic [4:0]  SRC_DUAL1    = 5'h18;
    localparam int unsigned LOWVOLT_MODE_BIT = 1;
    // Bit positions of the shared flags inside the second and fourth bytes
    localparam int unsigned DUAL0_BIT_IN_BYTE = 2;
    localparam int unsigned DUAL1_BIT_IN_BYTE = 0;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ACK   = 3'b010,
        ST_BREAK = 3'b100
    } ack_state_e;
endpackage : irq_src_pkg

/* src/pin_sync.sv */
// Two-stage synchroniser and edge selector for external request pins
`timescale 1ns/100ps
module pin_sync
    import irq_src_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    output logic      [W-1:0] rise_evt,
    output logic      [W-1:0] fall_evt,
    output logic      [W-1:0] level_q,
    output logic      [W-1:0] edge_evt
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Only sync_q may look at meta_q
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q  <= '0;
            sync_q  <= '0;
            level_q <= '0;
        end else begin
            meta_q  <= pin_in;
            sync_q  <= meta_q;
            level_q <= sync_q;
        end
    end

    // Edges from two settled stages; both may be enabled together
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            assign rise_evt[i] = sync_q[i] & ~level_q[i];
            assign fall_evt[i] = ~sync_q[i] & level_q[i];
            assign edge_evt[i] = (rise_evt[i] & rise_en[i]) | (fall_evt[i] & fall_en[i]);
        end
    endgenerate
endmodule : pin_sync

/* src/vectored_interrupt_source_control.sv */
// Source mapping, flags, arbitration and acknowledge of the vectored interrupt controller
`timescale 1ns/100ps
module vectored_interrupt_source_control
    import irq_src_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    // Internal source events, one-cycle pulses on clk
    input  wire logic [NUM_SRC-1:0]  src_evt,
    input  wire logic                sync_serial10_done_irq,
    input  wire logic                uart_a_tx_done_irq,
    input  wire logic                twowire_done_irq,
    input  wire logic                muldiv_done_irq,
    input  wire logic                timer8_b_match_irq,
    input  wire logic                carrier_timer_signal,
    // Mode controls of the dual-purpose sources
    input  wire logic                timer51_carrier_mode,
    input  wire logic                lowvolt_detect,
    input  wire logic                lowvolt_mode_select,
    // External pins, asynchronous
    input  wire logic [NUM_PINS-1:0] ext_pin,
    input  wire logic [NUM_KEYS-1:0] key_pin,
    input  wire logic [NUM_PINS-1:0] rise_edge_enable,
    input  wire logic [NUM_PINS-1:0] fall_edge_enable,
    input  wire logic [NUM_KEYS-1:0] key_return_mode_reg,
    // Flag register writes from software
    input  wire logic                flag_wr,
    input  wire logic [1:0]          flag_sel,
    input  wire logic [FLAG_W-1:0]   flag_wdata,
    input  wire logic [FLAG_W-1:0]   flag_wmask,
    // Program status word interface of the sequencer
    input  wire logic                global_enable,
    input  wire logic                in_service_prio_flag,
    input  wire logic                break_instruction,
    input  wire logic                ack_ready,
    // Offered vector and its handshake
    output logic                     irq_pending,
    output logic                     ack_valid,
    output logic [15:0]              vector_q,
    output logic                     ack_high_prio_q,
    output logic                     lowvolt_reset_q,
    // Flag registers as software reads them
    output logic [FLAG_W-1:0]        req_flags_q,
    output logic [FLAG_W-1:0]        mask_flags_q,
    output logic [FLAG_W-1:0]        prio_flags_q
);
    // Flag group codes on flag_sel
    localparam logic [1:0] SEL_REQ  = 2'h0;
    localparam logic [1:0] SEL_MASK = 2'h1;
    localparam logic [1:0] SEL_PRIO = 2'h2;

    // Acknowledge state
    ack_state_e          state_q;
    ack_state_e          state_d;
    logic                break_take;
    logic                mask_take;
    // Per-slot events and arbitration
    logic [NUM_SRC-1:0]  set_evt;
    logic [NUM_SRC-1:0]  eligible;
    logic [NUM_SRC-1:0]  eligible_hi;
    logic [NUM_SRC-1:0]  ack_clr;
    logic [FLAG_W-1:0]   req_flags_d;
    logic                req_wr;
    logic                mask_wr;
    logic                prio_wr;
    // Pin and key events
    logic [NUM_PINS-1:0] pin_evt;
    logic [NUM_KEYS-1:0] key_fall;
    logic                key_evt;
    logic                timer51_evt;
    logic                lowvolt_irq;
    // Winner of the current pick
    logic [4:0]          win_idx;
    logic                win_found;
    logic                win_hi;
    logic [4:0]          ack_idx_q;

    // Edge-selected pin events
    // Pin idle level is low, so reset leaves no false edge
    pin_sync #(.W(NUM_PINS)) u_pin_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .pin_in   (ext_pin),
        .rise_en  (rise_edge_enable),
        .fall_en  (fall_edge_enable),
        .rise_evt (),
        .fall_evt (),
        .level_q  (),
        .edge_evt (pin_evt)
    );

    // Key lines use falling edges only; enable mask does the qualifying
    // Rise events of key lines are left unused
    pin_sync #(.W(NUM_KEYS)) u_key_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .pin_in   (key_pin),
        .rise_en  ('0),
        .fall_en  (key_return_mode_reg),
        .rise_evt (),
        .fall_evt (key_fall),
        .level_q  (),
        .edge_evt ()
    );

    assign key_evt     = |(key_fall & key_return_mode_reg);
    assign timer51_evt = timer51_carrier_mode ? carrier_timer_signal
                                              : timer8_b_match_irq;
    assign lowvolt_irq = lowvolt_detect & ~lowvolt_mode_select;

    // Write strobes per flag group
    assign req_wr  = flag_wr & (flag_sel == SEL_REQ);
    assign mask_wr = flag_wr & (flag_sel == SEL_MASK);
    assign prio_wr = flag_wr & (flag_sel == SEL_PRIO);

    // Low-voltage detector as reset source in mode 1
    // Registered so a detector glitch never reaches the reset tree directly
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowvolt_reset_q <= 1'b0;
        end else begin
            lowvolt_reset_q <= lowvolt_detect & lowvolt_mode_select;
        end
    end

    // Gather events per source slot; shared slots OR their two events
    // Slots with a port of their own ignore src_evt
    always_comb begin
        set_evt                 = src_evt;
        set_evt[SRC_LOWVOLT]    = lowvolt_irq;
        set_evt[SRC_DUAL0]      = sync_serial10_done_irq | uart_a_tx_done_irq;
        set_evt[SRC_TIMER51]    = timer51_evt;
        set_evt[SRC_KEY]        = key_evt;
        set_evt[SRC_DUAL1]      = twowire_done_irq | muldiv_done_irq;
        for (int p = 0; p < 6; p++) begin
            set_evt[SRC_PIN0 + p[4:0]] = pin_evt[p];
        end
        set_evt[SRC_PIN6]       = pin_evt[6];
        set_evt[SRC_PIN6 + 5'h01] = pin_evt[7];
    end

    // Next request flags: software write, then acknowledge clear, then hardware set
    // Set is applied last so an event in the clear cycle is never lost
    always_comb begin
        req_flags_d = req_flags_q;
        if (req_wr) begin
            req_flags_d = (req_flags_d & ~flag_wmask) | (flag_wdata & flag_wmask);
        end
        req_flags_d = req_flags_d & ~{{(FLAG_W-NUM_SRC){1'b0}}, ack_clr};
        req_flags_d = req_flags_d | {{(FLAG_W-NUM_SRC){1'b0}}, set_evt};
        req_flags_d[FLAG_W-1:NUM_SRC] = '0; // Unused top bits read as zero
    end

    // Request flag register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_flags_q <= REQ_RESET;
        end else begin
            req_flags_q <= req_flags_d;
        end
    end

    // Mask flags; one bit per slot so shared slots share a mask
    // Software alone writes masks; hardware never sets them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_flags_q <= MASK_RESET;
        end else if (mask_wr) begin
            mask_flags_q <= (mask_flags_q & ~flag_wmask) | (flag_wdata & flag_wmask);
        end
    end

    // Priority flags, 1 means low priority; shared slots share one bit
    // Reset value marks every source low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prio_flags_q <= PRIO_RESET;
        end else if (prio_wr) begin
            prio_flags_q <= (prio_flags_q & ~flag_wmask) | (flag_wdata & flag_wmask);
        end
    end

    // Eligibility; in-service flag low blocks low-priority sources
    // In-service flag high lets both levels through
    always_comb begin
        for (int s = 0; s < NUM_SRC; s++) begin
            eligible[s] = req_flags_q[s] & ~mask_flags_q[s] & global_enable
                          & (in_service_prio_flag | ~prio_flags_q[s]);
            eligible_hi[s] = eligible[s] & ~prio_flags_q[s];
        end
    end

    // Fixed-order pick, high-priority group first
    // Loops run downward so the lowest index is left; the high pass overrides
    always_comb begin
        win_idx   = 5'h00;
        win_found = 1'b0;
        win_hi    = 1'b0;
        for (int s = NUM_SRC - 1; s >= 0; s--) begin
            if (eligible[s]) begin
                win_idx   = s[4:0];
                win_found = 1'b1;
            end
        end
        for (int s = NUM_SRC - 1; s >= 0; s--) begin
            if (eligible_hi[s]) begin
                win_idx = s[4:0];
                win_hi  = 1'b1;
            end
        end
    end

    // Pending and offer flags for the sequencer
    assign irq_pending = win_found | break_instruction;
    assign ack_valid   = (state_q == ST_ACK) | (state_q == ST_BREAK);
    // Break is taken ahead of any maskable request, and only from idle
    assign break_take  = (state_q == ST_IDLE) & break_instruction;
    assign mask_take   = (state_q == ST_IDLE) & ~break_instruction & win_found;

    // Acknowledge sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            // Break goes ahead of maskable requests
            ST_IDLE: begin
                if (break_instruction) begin
                    state_d = ST_BREAK;
                end else if (win_found) begin
                    state_d = ST_ACK;
                end
            end
            // Vector stands until the sequencer takes it
            ST_ACK: begin
                if (ack_ready) begin
                    state_d = ST_IDLE;
                end
            end
            // Break has no flag to clear on the take
            ST_BREAK: begin
                if (ack_ready) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Acknowledge state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Latch winner so vector holds while the sequencer takes it
    // Index kept so the take clears the right flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_idx_q       <= 5'h00;
            vector_q        <= VEC_RESET;
            ack_high_prio_q <= 1'b0;
        end else if (break_take) begin
            vector_q        <= VEC_BREAK;
            ack_high_prio_q <= 1'b0;
        end else if (mask_take) begin
            ack_idx_q       <= win_idx;
            vector_q        <= VEC_BASE + {10'h000, win_idx, 1'b0};
            ack_high_prio_q <= win_hi;
        end
    end

    // Clear request flag at acknowledge handshake
    // Only maskable offers clear a flag; break leaves them alone
    always_comb begin
        ack_clr = '0;
        if (state_q == ST_ACK && ack_ready) begin
            ack_clr[ack_idx_q] = 1'b1;
        end
    end
endmodule : vectored_interrupt_source_control

/* tb/cpu_seq_model.sv */
// Behavioural CPU sequencer that takes offered vectors, promptly or slowly
`timescale 1ns/100ps
module cpu_seq_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ack_valid,
    input  wire logic slow,
    output logic      ack_ready
);
    logic [1:0] wait_q;
    // Ready is dropped right after the take, so one offer is never taken twice
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q    <= 2'h0;
            ack_ready <= 1'b0;
        end else if (!ack_valid || ack_ready) begin
            wait_q    <= 2'h0;
            ack_ready <= 1'b0;
        end else begin
            wait_q    <= wait_q + 2'h1;
            ack_ready <= !slow || wait_q == 2'h3;
        end
    end
endmodule : cpu_seq_model

/* tb/irq_src_monitor.sv */
// Port-level checker for the vectored interrupt source controller
`timescale 1ns/100ps
module irq_src_monitor
    import irq_src_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              global_enable,
    input wire logic              in_service_prio_flag,
    input wire logic              break_instruction,
    input wire logic              ack_ready,
    input wire logic              lowvolt_detect,
    input wire logic              lowvolt_mode_select,
    input wire logic              sync_serial10_done_irq,
    input wire logic              uart_a_tx_done_irq,
    input wire logic              twowire_done_irq,
    input wire logic              muldiv_done_irq,
    input wire logic              irq_pending,
    input wire logic              ack_valid,
    input wire logic [15:0]       vector_q,
    input wire logic              lowvolt_reset_q,
    input wire logic [FLAG_W-1:0] req_flags_q,
    input wire logic [FLAG_W-1:0] mask_flags_q,
    input wire logic [FLAG_W-1:0] prio_flags_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Requests acceptable under the current status word; prio bit 1 means low
    logic [FLAG_W-1:0] elig;
    assign elig = req_flags_q & ~mask_flags_q & (in_service_prio_flag ? '1 : ~prio_flags_q);

    a_vec_legal: assert property (ack_valid |-> vector_q == VEC_BREAK ||
        (vector_q >= 16'h0004 && vector_q <= 16'h003c && !vector_q[0]))
        else $error("vector outside table");
    a_ack_stands: assert property (ack_valid && !ack_ready |=> ack_valid && $stable(vector_q))
        else $error("offered vector withdrawn");
    a_ack_release: assert property (ack_valid && ack_ready |=> !ack_valid)
        else $error("offer kept after take");
    a_pend_to_ack: assert property (irq_pending && !ack_valid |-> ##[1:2] ack_valid)
        else $error("pending request not offered");
    a_pend_elig: assert property (irq_pending && !break_instruction |->
        global_enable && |elig[NUM_SRC-1:0])
        else $error("pending without eligible request");
    a_elig_pends: assert property (global_enable && |elig[NUM_SRC-1:0] |-> irq_pending)
        else $error("eligible request not pending");
    a_lowvolt_rst: assert property (lowvolt_detect && lowvolt_mode_select |=> lowvolt_reset_q)
        else $error("low-voltage reset missing");
    a_dual0_set: assert property (sync_serial10_done_irq || uart_a_tx_done_irq |=>
        req_flags_q[SRC_DUAL0])
        else $error("shared serial flag not set");
    a_dual1_set: assert property (twowire_done_irq || muldiv_done_irq |=>
        req_flags_q[SRC_DUAL1])
        else $error("shared two-wire flag not set");

    c_break: cover property (ack_valid && ack_ready && vector_q == VEC_BREAK);
    c_last: cover property (ack_valid && ack_ready && vector_q == 16'h003c);
    c_lowvolt: cover property (lowvolt_reset_q);
endmodule : irq_src_monitor

bind vectored_interrupt_source_control irq_src_monitor u_mon (.*);

/* tb/vectored_interrupt_source_control_test.sv */
// Self-checking bench for the vectored interrupt source controller
`timescale 1ns/100ps
module vectored_interrupt_source_control_test
    import irq_src_pkg::*;
;
    logic clk, rst_b, flag_wr, global_enable, in_service_prio_flag, break_instruction, slow;
    logic ack_ready, irq_pending, ack_valid, ack_high_prio_q, lowvolt_reset_q;
    logic sync_serial10_done_irq, uart_a_tx_done_irq, twowire_done_irq, muldiv_done_irq;
    logic timer8_b_match_irq, carrier_timer_signal, timer51_carrier_mode;
    logic lowvolt_detect, lowvolt_mode_select;
    logic [NUM_SRC-1:0] src_evt;
    logic [7:0]         ext_pin, key_pin, rise_edge_enable, fall_edge_enable, key_return_mode_reg;
    logic [1:0]         flag_sel;
    logic [FLAG_W-1:0]  flag_wdata, flag_wmask, req_flags_q, mask_flags_q, prio_flags_q;
    logic [15:0]        vector_q;
    logic [15:0]        got[$];
    int                 err_count, samples_checked;

    vectored_interrupt_source_control dut (.*);
    cpu_seq_model seq (.*);

    always #2.5 clk = ~clk;
    // Record each vector at the edge where the sequencer takes it
    always @(posedge clk) if (ack_valid === 1'b1 && ack_ready === 1'b1) got.push_back(vector_q);

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Flag write; one idle edge after so the strobe is never re-raised at once
    task automatic wr(input logic [1:0] sel, input logic [31:0] d, input logic [31:0] m);
        flag_sel = sel;
        flag_wdata = d;
        flag_wmask = m;
        flag_wr = 1'b1;
        tick(1);
        flag_wr = 1'b0;
        tick(1);
    endtask : wr
    task automatic serve(input int n);
        for (int i = 0; i < 200 && got.size() < n; i++) tick(1);
        chk(got.size(), n);
    endtask : serve
    task automatic t_order();
        got.delete();
        wr(2'h1, '0, '1);
        global_enable = 1'b1;
        src_evt[28] = 1'b1;
        src_evt[7] = 1'b1;
        sync_serial10_done_irq = 1'b1;
        tick(1);
        src_evt = '0;
        sync_serial10_done_irq = 1'b0;
        serve(3);
        tick(1);
        chk(got[0], 16'h0012);
        chk(got[1], 16'h0018);
        chk(got[2], 16'h003c);
        chk(ack_high_prio_q, 1'b0);
        chk(req_flags_q, 32'h0);
        $display("t_order done");
    endtask : t_order
    task automatic t_prio();
        got.delete();
        wr(2'h2, '0, 32'h0100_0000);
        in_service_prio_flag = 1'b0;
        src_evt[9] = 1'b1;
        muldiv_done_irq = 1'b1;
        tick(1);
        src_evt[9] = 1'b0;
        muldiv_done_irq = 1'b0;
        serve(1);
        chk(got[0], 16'h0034);
        chk(ack_high_prio_q, 1'b1);
        tick(3);
        chk(irq_pending, 1'b0);
        chk(req_flags_q[9], 1'b1);
        in_service_prio_flag = 1'b1;
        serve(2);
        chk(got[1], 16'h0016);
        $display("t_prio done");
    endtask : t_prio
    task automatic t_mask();
        got.delete();
        wr(2'h1, 32'h0100_0400, 32'h0100_0400);
        wr(2'h2, '0, 32'h0000_0400);
        uart_a_tx_done_irq = 1'b1;
        twowire_done_irq = 1'b1;
        tick(1);
        uart_a_tx_done_irq = 1'b0;
        twowire_done_irq = 1'b0;
        tick(2);
        chk(irq_pending, 1'b0);
        chk({req_flags_q[24], req_flags_q[10]}, 2'b11);
        global_enable = 1'b0;
        wr(2'h1, '0, 32'h0100_0400);
        chk(irq_pending, 1'b0);
        in_service_prio_flag = 1'b0;
        global_enable = 1'b1;
        serve(2);
        chk(got[0], 16'h0018);
        chk(got[1], 16'h0034);
        in_service_prio_flag = 1'b1;
        global_enable = 1'b0;
        $display("t_mask done");
    endtask : t_mask
    // Break is held until taken and accepted with interrupts disabled
    task automatic t_break();
        got.delete();
        slow = 1'b1;
        break_instruction = 1'b1;
        serve(1);
        break_instruction = 1'b0;
        slow = 1'b0;
        chk(got[0], 16'h003e);
        $display("t_break done");
    endtask : t_break
    task automatic t_modes();
        lowvolt_mode_select = 1'b1;
        lowvolt_detect = 1'b1;
        tick(1);
        lowvolt_detect = 1'b0;
        chk({lowvolt_reset_q, req_flags_q[0]}, 2'b10);
        lowvolt_mode_select = 1'b0;
        lowvolt_detect = 1'b1;
        tick(1);
        lowvolt_detect = 1'b0;
        chk({lowvolt_reset_q, req_flags_q[0]}, 2'b01);
        timer51_carrier_mode = 1'b1;
        timer8_b_match_irq = 1'b1;
        tick(1);
        timer8_b_match_irq = 1'b0;
        chk(req_flags_q[19], 1'b0);
        carrier_timer_signal = 1'b1;
        tick(1);
        carrier_timer_signal = 1'b0;
        chk(req_flags_q[19], 1'b1);
        wr(2'h0, '0, '1);
        timer51_carrier_mode = 1'b0;
        carrier_timer_signal = 1'b1;
        tick(1);
        carrier_timer_signal = 1'b0;
        chk(req_flags_q[19], 1'b0);
        timer8_b_match_irq = 1'b1;
        tick(1);
        timer8_b_match_irq = 1'b0;
        chk(req_flags_q[19], 1'b1);
        $display("t_modes done");
    endtask : t_modes
    // Pins need three edges to show an event, so wait six
    task automatic t_pins();
        wr(2'h0, '0, '1);
        rise_edge_enable = 8'h05;
        fall_edge_enable = 8'h06;
        ext_pin = 8'h07;
        tick(6);
        chk(req_flags_q[6:1], 6'h05);
        wr(2'h0, '0, '1);
        ext_pin = 8'h00;
        tick(6);
        chk(req_flags_q[6:1], 6'h06);
        key_return_mode_reg = 8'h01;
        key_pin = 8'hfd;
        tick(6);
        chk(req_flags_q[20], 1'b0);
        key_pin = 8'hfc;
        tick(6);
        chk(req_flags_q[20], 1'b1);
        $display("t_pins done");
    endtask : t_pins
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    initial begin
        {clk, rst_b, flag_wr, global_enable, break_instruction, slow, src_evt} = '0;
        {sync_serial10_done_irq, uart_a_tx_done_irq, twowire_done_irq, muldiv_done_irq} = '0;
        {timer8_b_match_irq, carrier_timer_signal, timer51_carrier_mode} = '0;
        {lowvolt_detect, lowvolt_mode_select, flag_sel, flag_wdata, flag_wmask} = '0;
        {ext_pin, rise_edge_enable, fall_edge_enable, key_return_mode_reg} = '0;
        key_pin = 8'hff;
        in_service_prio_flag = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        chk(req_flags_q, 32'h0);
        chk(mask_flags_q, 32'hffff_ffff);
        chk(prio_flags_q, PRIO_RESET);
        t_order();
        t_prio();
        t_mask();
        t_break();
        t_modes();
        t_pins();
        complete_run();
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule : vectored_interrupt_source_control_test
